// ---- design/dpw_defs.vh ----
// constants for the dual wiper two-wire slave
`ifndef DPW_DEFS_VH
`define DPW_DEFS_VH

// ==========================================
// identification byte
`define DPW_DEV_ID 4'h5
`define DPW_STRAP_W 4

// ==========================================
// byte framing
`define DPW_BYTE_BITS 4'h8

// ==========================================
// instruction byte layout and opcodes
`define DPW_OP_HI 7
`define DPW_OP_LO 4
`define DPW_RSEL_HI 3
`define DPW_RSEL_LO 2
`define DPW_POT_BIT 0
`define DPW_OP_RD_WIPER 4'h9
`define DPW_OP_WR_WIPER 4'hA
`define DPW_OP_RD_PRESET 4'hB
`define DPW_OP_WR_PRESET 4'hC
`define DPW_OP_XFR_TO_WIPER 4'hD
`define DPW_OP_XFR_TO_PRESET 4'hE
`define DPW_OP_GXFR_TO_WIPER 4'h1
`define DPW_OP_GXFR_TO_PRESET 4'h8

// ==========================================
// register file shape and reset values
`define DPW_PRESETS 8
`define DPW_PRESET_RST 8'h80
`define DPW_TAPS 256

`endif

// ---- design/dpw_pin_sync.v ----
// three-stage pin synchroniser with agreement filter
module dpw_pin_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
  input wire ref_clk_i,
  input wire reset_i,
  input wire [W-1:0] pin_i,
  output wire [W-1:0] level_o
);

  reg [W-1:0] meta_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  reg [W-1:0] level_q;

  // ==========================================
  // sampling chain
  // meta_q feeds only s2_q; the filter looks at stages two and three
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      meta_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      level_q <= RST_VAL;
    end else begin
      meta_q <= pin_i;
      s2_q <= meta_q;
      s3_q <= s2_q;
      level_q <= (s2_q & ~(s2_q ^ s3_q)) | (level_q & (s2_q ^ s3_q));
    end
  end

  assign level_o = level_q;

endmodule // dpw_pin_sync

// ---- design/dpw_tap_decode.v ----
// one-hot tap switch decoder for one potentiometer
`include "dpw_defs.vh"
module dpw_tap_decode (
  input wire ref_clk_i,
  input wire reset_i,
  input wire [7:0] pos_i,
  output wire [`DPW_TAPS-1:0] tap_en_o
);

  reg [`DPW_TAPS-1:0] tap_q;

  // ==========================================
  // registered decode, one flop per switch
  // equality against a distinct constant per bit keeps it one-hot by construction
  genvar i;
  generate
    for (i = 0; i < `DPW_TAPS; i = i + 1) begin : g_tap
      always @(posedge ref_clk_i) begin
        if (reset_i) begin
          tap_q[i] <= ({24'h000000, `DPW_PRESET_RST} == i);
        end else begin
          tap_q[i] <= ({24'h000000, pos_i} == i);
        end
      end
    end
  endgenerate

  assign tap_en_o = tap_q;

endmodule // dpw_tap_decode

// ---- design/dpw_wiper_ctrl.v ----
// two-wire slave controlling two wiper position and preset registers
`include "dpw_defs.vh"

module dpw_wiper_ctrl (
  input wire ref_clk_i,
  input wire reset_i,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  input wire [`DPW_STRAP_W-1:0] address_strap_inputs_i,
  input wire write_protect_n_i,
  output wire [`DPW_TAPS-1:0] tap_en0_o,
  output wire [`DPW_TAPS-1:0] tap_en1_o
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ID = 3'd1;
  localparam [2:0] ST_INSTR = 3'd2;
  localparam [2:0] ST_RX = 3'd3;
  localparam [2:0] ST_ACK = 3'd4;
  localparam [2:0] ST_TX = 3'd5;

  wire scl_s;
  wire sda_s;
  wire wp_n_s;
  wire [`DPW_STRAP_W-1:0] strap_s;
  reg scl_p_q;
  reg sda_p_q;
  reg [2:0] state_q;
  reg [2:0] after_ack_q;
  reg [3:0] cnt_q;
  reg [7:0] shift_q;
  reg [7:0] tx_q;
  reg [7:0] instr_q;
  reg sda_oe_q;
  reg load_q;
  reg [7:0] wiper_q [0:1];
  reg [7:0] preset_q [0:`DPW_PRESETS-1];
  integer k;

  // preset array index from pot number and register select
  function [2:0] pidx;
    input pot;
    input [1:0] rsel;
    begin
      pidx = {pot, rsel};
    end
  endfunction

  // ==========================================
  // pin synchronisers
  dpw_pin_sync #(.W(1), .RST_VAL(1'b1)) u_scl_sync (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .pin_i(scl_i),
    .level_o(scl_s)
  );

  dpw_pin_sync #(.W(1), .RST_VAL(1'b1)) u_sda_sync (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .pin_i(sda_i),
    .level_o(sda_s)
  );

  // protect pin resets to blocked so nothing slips out before it settles
  dpw_pin_sync #(.W(1), .RST_VAL(1'b0)) u_wp_sync (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .pin_i(write_protect_n_i),
    .level_o(wp_n_s)
  );

  dpw_pin_sync #(.W(`DPW_STRAP_W), .RST_VAL({`DPW_STRAP_W{1'b0}})) u_strap_sync (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .pin_i(address_strap_inputs_i),
    .level_o(strap_s)
  );

  // ==========================================
  // bus event detection
  // start and stop demand scl high in both samples, so a data edge
  // racing an scl edge is never taken for a condition
  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire bus_stop = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire byte_done = (cnt_q == `DPW_BYTE_BITS);

  // decoded fields of the byte just received and of the stored instruction byte
  wire [3:0] op_now = shift_q[`DPW_OP_HI:`DPW_OP_LO];
  wire [1:0] rsel_now = shift_q[`DPW_RSEL_HI:`DPW_RSEL_LO];
  wire pot_now = shift_q[`DPW_POT_BIT];
  wire [3:0] op_q = instr_q[`DPW_OP_HI:`DPW_OP_LO];
  wire [1:0] rsel_q = instr_q[`DPW_RSEL_HI:`DPW_RSEL_LO];
  wire pot_q = instr_q[`DPW_POT_BIT];
  // all four strap pins take part in the compare, not only the low three
  wire id_match = (shift_q[7:4] == `DPW_DEV_ID) && (shift_q[3:0] == strap_s);
  wire is_read = (op_now == `DPW_OP_RD_WIPER) || (op_now == `DPW_OP_RD_PRESET);
  wire is_write = (op_now == `DPW_OP_WR_WIPER) || (op_now == `DPW_OP_WR_PRESET);

  // read data chosen from the stored instruction
  wire [7:0] rd_byte = (op_q == `DPW_OP_RD_WIPER) ? wiper_q[pot_q] :
                       preset_q[pidx(pot_q, rsel_q)];

  // ==========================================
  // edge history
  // reset to the idle high level so the release shows no false edge
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // ==========================================
  // protocol engine
  // scl is only ever an input here, the master owns the clock
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      after_ack_q <= ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      instr_q <= 8'h00;
      sda_oe_q <= 1'b0;
    end else if (bus_stop) begin
      state_q <= ST_IDLE;
      sda_oe_q <= 1'b0;
      cnt_q <= 4'h0;
    end else if (bus_start) begin
      state_q <= ST_ID;
      sda_oe_q <= 1'b0;
      cnt_q <= 4'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // nothing on the bus matters until a start
          cnt_q <= 4'h0;
        end
        ST_ID, ST_INSTR, ST_RX: begin
          if (scl_rise && !byte_done) begin
            shift_q <= {shift_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && byte_done) begin
            cnt_q <= 4'h0;
            if (state_q == ST_ID) begin
              // a foreign address leaves the bus alone until next start
              sda_oe_q <= id_match;
              state_q <= id_match ? ST_ACK : ST_IDLE;
              after_ack_q <= ST_INSTR;
            end else if (state_q == ST_INSTR) begin
              instr_q <= shift_q;
              sda_oe_q <= 1'b1;
              state_q <= ST_ACK;
              after_ack_q <= is_read ? ST_TX : (is_write ? ST_RX : ST_IDLE);
            end else begin
              sda_oe_q <= 1'b1;
              state_q <= ST_ACK;
              after_ack_q <= ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          // acknowledge lasts from the eighth fall to the ninth fall
          if (scl_fall) begin
            state_q <= after_ack_q;
            cnt_q <= 4'h0;
            // whole byte taken here, so a later register change cannot tear a read
            if (after_ack_q == ST_TX) begin
              sda_oe_q <= ~rd_byte[7];
              tx_q <= {rd_byte[6:0], 1'b0};
            end else begin
              sda_oe_q <= 1'b0;
            end
          end
        end
        ST_TX: begin
          // one byte per read; the master ack slot is left to the master
          if (scl_rise) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (byte_done) begin
              sda_oe_q <= 1'b0;
              state_q <= ST_IDLE;
            end else begin
              sda_oe_q <= ~tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // register file
  // presets have no real retention here; reset stands in for the stored value
  wire instr_done = (state_q == ST_INSTR) && scl_fall && byte_done && !bus_start && !bus_stop;
  wire data_done = (state_q == ST_RX) && scl_fall && byte_done && !bus_start && !bus_stop;

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      load_q <= 1'b1;
      for (k = 0; k < 2; k = k + 1) begin
        wiper_q[k] <= `DPW_PRESET_RST;
      end
      for (k = 0; k < `DPW_PRESETS; k = k + 1) begin
        preset_q[k] <= `DPW_PRESET_RST;
      end
    end else if (load_q) begin
      // power-up recall of preset zero
      load_q <= 1'b0;
      wiper_q[0] <= preset_q[pidx(1'b0, 2'd0)];
      wiper_q[1] <= preset_q[pidx(1'b1, 2'd0)];
    end else if (data_done) begin
      if (op_q == `DPW_OP_WR_WIPER) begin
        wiper_q[pot_q] <= shift_q;
      end else if (op_q == `DPW_OP_WR_PRESET && wp_n_s) begin
        preset_q[pidx(pot_q, rsel_q)] <= shift_q;
      end
    end else if (instr_done) begin
      // transfers act on the instruction byte itself, no data byte follows
      case (op_now)
        `DPW_OP_XFR_TO_WIPER: begin
          wiper_q[pot_now] <= preset_q[pidx(pot_now, rsel_now)];
        end
        `DPW_OP_XFR_TO_PRESET: begin
          if (wp_n_s) begin
            preset_q[pidx(pot_now, rsel_now)] <= wiper_q[pot_now];
          end
        end
        `DPW_OP_GXFR_TO_WIPER: begin
          wiper_q[0] <= preset_q[pidx(1'b0, rsel_now)];
          wiper_q[1] <= preset_q[pidx(1'b1, rsel_now)];
        end
        `DPW_OP_GXFR_TO_PRESET: begin
          if (wp_n_s) begin
            preset_q[pidx(1'b0, rsel_now)] <= wiper_q[0];
            preset_q[pidx(1'b1, rsel_now)] <= wiper_q[1];
          end
        end
        default: begin
          load_q <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // pin and tap outputs
  // data level is always low; only the enable moves, so the line is never driven high
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_q;

  dpw_tap_decode u_tap0 (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .pos_i(wiper_q[0]),
    .tap_en_o(tap_en0_o)
  );

  dpw_tap_decode u_tap1 (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .pos_i(wiper_q[1]),
    .tap_en_o(tap_en1_o)
  );

endmodule // dpw_wiper_ctrl

// ---- sim/dpw_master_model.sv ----
// two-wire bus master model with a 48 ns bit period
module dpw_master_model (
  output logic scl_o,
  output logic sda_pull_o,
  input wire logic sda_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus: both lines released high
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  // ==========================================
  // start: data falls while clock high
  task automatic start_c();
    #12 sda_pull_o = 1'b0;
    #12 scl_o = 1'b1;
    #12 sda_pull_o = 1'b1;
    #12 scl_o = 1'b0;
  endtask
  // stop: data rises while clock high
  task automatic stop_c();
    #12 sda_pull_o = 1'b1;
    #12 scl_o = 1'b1;
    #12 sda_pull_o = 1'b0;
    #12;
  endtask
  // one bit; clock lowered first so data never moves in a high phase
  task automatic bit_c(input logic b, output logic r);
    scl_o = 1'b0;
    #12 sda_pull_o = !b;
    #12 scl_o = 1'b1;
    #12 r = sda_i;
    #12 scl_o = 1'b0;
  endtask
  // byte msb first, then a released ninth clock
  task automatic byte_c(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_c(d[i], q[i]);
    end
    bit_c(1'b1, a);
    ack = !a;
  endtask
endmodule // dpw_master_model

// ---- sim/dpw_wiper_ctrl_properties.sv ----
// concurrent checks on the pins of the dual wiper two-wire slave
`include "dpw_defs.vh"
module dpw_wiper_ctrl_properties (
  input wire ref_clk_i,
  input wire reset_i,
  input wire scl_i,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire [`DPW_STRAP_W-1:0] address_strap_inputs_i,
  input wire write_protect_n_i,
  input wire [`DPW_TAPS-1:0] tap_en0_o,
  input wire [`DPW_TAPS-1:0] tap_en1_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  logic [3:0] hi_cnt_q;
  logic [7:0] oe_cnt_q;
  // ==========================================
  // run lengths of scl high and of the pull-down, saturating so they never wrap
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      hi_cnt_q <= 4'h0;
      oe_cnt_q <= 8'h00;
    end else begin
      hi_cnt_q <= !scl_i ? 4'h0 : (hi_cnt_q == 4'hF) ? 4'hF : hi_cnt_q + 4'h1;
      oe_cnt_q <= !sda_oe_o ? 8'h00 : (oe_cnt_q == 8'hFF) ? 8'hFF : oe_cnt_q + 8'h01;
    end
  end
  // ==========================================
  // named steps
  sequence s_release;
    $fell(reset_i);
  endsequence
  sequence s_pull;
    $rose(sda_oe_o);
  endsequence
  // ==========================================
  // assertions
  AST_SDA_OPEN_DRAIN: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  AST_TAP0_ONEHOT: assert property ($onehot(tap_en0_o))
    else $error("pot0 taps not one-hot");
  AST_TAP1_ONEHOT: assert property ($onehot(tap_en1_o))
    else $error("pot1 taps not one-hot");
  AST_RELEASE_TAPS: assert property (s_release |-> (tap_en0_o[128] && tap_en1_o[128])[*4])
    else $error("taps not at default preset after reset");
  // the pin path is a few cycles long, so scl is looked at a little earlier
  AST_OE_IN_LOW_PHASE: assert property ($changed(sda_oe_o) |-> !$past(scl_i, 3))
    else $error("pull-down changed in scl high phase");
  AST_OE_HOLD: assert property (s_pull |=> sda_oe_o[*7])
    else $error("pull-down too short");
  AST_IDLE_RELEASED: assert property (hi_cnt_q == 4'hF |-> !sda_oe_o)
    else $error("data held low on idle bus");
  AST_OE_BOUNDED: assert property (oe_cnt_q <= 8'h82)
    else $error("data held low too long");
endmodule // dpw_wiper_ctrl_properties

bind dpw_wiper_ctrl dpw_wiper_ctrl_properties u_props (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .address_strap_inputs_i(address_strap_inputs_i),
  .write_protect_n_i(write_protect_n_i), .tap_en0_o(tap_en0_o), .tap_en1_o(tap_en1_o)
);

// ---- sim/dpw_wiper_ctrl_tb_top.sv ----
// self-checking bench for the dual wiper two-wire slave
`include "dpw_defs.vh"
module dpw_wiper_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] strap = 4'h0;
  logic wp_n = 1'b1;
  logic [7:0] idb = 8'h00;
  logic m_scl;
  logic m_pull;
  logic dut_oe;
  logic [`DPW_TAPS-1:0] tap0;
  logic [`DPW_TAPS-1:0] tap1;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  // wired-and data line with pull-up
  wire sda_w = !(m_pull || dut_oe);

  dpw_wiper_ctrl u_dut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .scl_i(m_scl), .sda_i(sda_w), .sda_o(),
    .sda_oe_o(dut_oe), .address_strap_inputs_i(strap), .write_protect_n_i(wp_n),
    .tap_en0_o(tap0), .tap_en1_o(tap1)
  );
  dpw_master_model u_mst (.scl_o(m_scl), .sda_pull_o(m_pull), .sda_i(sda_w));

  // 250 MHz clock
  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  // hang guard, well above the roughly 10600 cycles the run needs
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count = fail_count + 1;
      summarize();
    end
  end
  // ==========================================
  // helpers
  function automatic logic [7:0] mk_ins(input logic [3:0] op, input logic [1:0] r, input logic p);
    return {op, r, 1'b0, p};
  endfunction
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_tap(input string nm, input logic [7:0] pos, input logic [`DPW_TAPS-1:0] g);
    logic [`DPW_TAPS-1:0] e;
    e = {{(`DPW_TAPS-1){1'b0}}, 1'b1} << pos;
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // mode 0 write, 1 read, 2 no data byte; ack bits id, instr, data
  task automatic cmd(input logic [7:0] id, input logic [7:0] ins, input logic [7:0] dat, input int mode,
                     output logic [7:0] q, output logic [2:0] ak);
    logic [7:0] junk;
    logic nk;
    ak = 3'b000;
    q = 8'h00;
    u_mst.start_c();
    u_mst.byte_c(id, junk, ak[2]);
    if (ak[2]) u_mst.byte_c(ins, junk, ak[1]);
    if (ak[1] && mode == 0) u_mst.byte_c(dat, junk, ak[0]);
    if (ak[1] && mode == 1) u_mst.byte_c(8'hFF, q, nk);
    u_mst.stop_c();
    repeat (8) @(posedge ref_clk_i);
    // leave off the sampling edge, so pin moves and result checks never race the clock
    #1;
  endtask
  // ==========================================
  // main sequence
  initial begin
    logic [7:0] q;
    logic [7:0] v;
    logic [7:0] w0;
    logic [7:0] w1;
    logic [7:0] junk;
    logic [2:0] ak;
    logic nk;
    v = 8'($urandom(75));
    strap = 4'($urandom);
    idb = {`DPW_DEV_ID, strap};
    repeat (20) @(posedge ref_clk_i);
    #1 reset_i = 1'b0;
    repeat (12) @(posedge ref_clk_i);
    #1;
    chk_tap("tap0 power-up", `DPW_PRESET_RST, tap0);
    chk_tap("tap1 power-up", `DPW_PRESET_RST, tap1);
    // a whole id byte with no start in front goes unanswered
    u_mst.byte_c(idb, junk, nk);
    chk8("ack no start", 8'h00, {7'h00, nk});
    u_mst.stop_c();
    cmd({4'h3, strap}, mk_ins(4'hA, 2'd0, 1'b0), 8'h12, 0, q, ak);
    chk8("ack wrong id", 8'h00, {5'h00, ak});
    cmd({`DPW_DEV_ID, ~strap}, mk_ins(4'hA, 2'd0, 1'b0), 8'h12, 0, q, ak);
    chk8("ack wrong strap", 8'h00, {5'h00, ak});
    // wiper writes and reads, end values first
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      cmd(idb, mk_ins(4'hA, 2'd0, i[0]), v, 0, q, ak);
      chk8("ack wiper write", 8'h07, {5'h00, ak});
      chk_tap("tap after write", v, i[0] ? tap1 : tap0);
      cmd(idb, mk_ins(4'h9, 2'd0, i[0]), 8'h00, 1, q, ak);
      chk8("wiper read", v, q);
    end
    // preset write with protect low is acked but dropped
    @(posedge ref_clk_i);
    #1 wp_n = 1'b0;
    cmd(idb, mk_ins(4'hC, 2'd2, 1'b0), 8'h11, 0, q, ak);
    chk8("ack protected write", 8'h07, {5'h00, ak});
    cmd(idb, mk_ins(4'hB, 2'd2, 1'b0), 8'h00, 1, q, ak);
    chk8("protected preset", `DPW_PRESET_RST, q);
    @(posedge ref_clk_i);
    #1 wp_n = 1'b1;
    v = 8'($urandom);
    cmd(idb, mk_ins(4'hC, 2'd3, 1'b1), v, 0, q, ak);
    cmd(idb, mk_ins(4'hB, 2'd3, 1'b1), 8'h00, 1, q, ak);
    chk8("preset read", v, q);
    cmd(idb, mk_ins(4'hD, 2'd3, 1'b1), 8'h00, 2, q, ak);
    chk8("ack transfer", 8'h06, {5'h00, ak});
    chk_tap("tap1 after transfer", v, tap1);
    cmd(idb, mk_ins(4'h1, 2'd0, 1'b0), 8'h00, 2, q, ak);
    chk_tap("tap0 global recall", `DPW_PRESET_RST, tap0);
    chk_tap("tap1 global recall", `DPW_PRESET_RST, tap1);
    // wiper to preset copies; msb clear keeps both values apart from the reset preset
    w0 = {1'b0, 7'($urandom)};
    w1 = {1'b0, 7'($urandom)};
    cmd(idb, mk_ins(4'hA, 2'd0, 1'b0), w0, 0, q, ak);
    cmd(idb, mk_ins(4'hA, 2'd0, 1'b1), w1, 0, q, ak);
    @(posedge ref_clk_i);
    #1 wp_n = 1'b0;
    cmd(idb, mk_ins(4'h8, 2'd1, 1'b0), 8'h00, 2, q, ak);
    cmd(idb, mk_ins(4'hB, 2'd1, 1'b1), 8'h00, 1, q, ak);
    chk8("protected global store", `DPW_PRESET_RST, q);
    @(posedge ref_clk_i);
    #1 wp_n = 1'b1;
    cmd(idb, mk_ins(4'hE, 2'd1, 1'b0), 8'h00, 2, q, ak);
    cmd(idb, mk_ins(4'hB, 2'd1, 1'b0), 8'h00, 1, q, ak);
    chk8("wiper store", w0, q);
    cmd(idb, mk_ins(4'h8, 2'd1, 1'b0), 8'h00, 2, q, ak);
    cmd(idb, mk_ins(4'hB, 2'd1, 1'b1), 8'h00, 1, q, ak);
    chk8("global wiper store", w1, q);
    summarize();
  end
endmodule // dpw_wiper_ctrl_tb_top
